// *** hw/mss_memory_space_select.sv ***
/*
 * mss_memory_space_select.sv: program/data memory space selection and
 * multiplexed external memory bus sequencer with internal data decode.
 * Assumes the core issues one request at a time on sys_clk and that pins
 * reach the testbench as input, output and output enable (enable low = drive).
 * Strap and reset pins are synchronised; the data port is sampled on the rising edge that ends the strobe.
 */
// Functional notes
// RULE1 - reset after rst pin high two machine cycles
// RULE2 - address valid on bus while latch strobe high
// RULE3 - fetch strobe low enables external program memory
// RULE4 - low address and data share first port
// RULE5 - high address byte on third port
// RULE6 - port four bit7 reads, bit6 writes
// RULE7 - interrupt vectors eight apart from 0003H
// RULE8 - unused vector locations hold ordinary code
// RULE9 - program space 64K, 0000H to FFFFH
// RULE10 - select low at reset: all fetches external
// RULE11 - select high at reset: low 4K internal
// RULE12 - above 0FFFH always fetch externally
// RULE13 - external data reached by external move, pointer
// RULE14 - external move also takes 8-bit indexed address
// RULE15 - 192 bytes internal data, 00H to BFH
// RULE16 - special registers upper 128, direct only
// RULE17 - overlapping RAM reachable only indirectly
// RULE18 - never fetch and data strobes together
`timescale 1ns/100ps
`include "mss_defs.svh"

module mss_memory_space_select
	import mss_pkg::*;
#(
	parameter int RESET_CLKS = `MSS_RESET_CLKS
)(
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic        reset_pin,
	input  wire logic        external_fetch_select,
	input  wire logic        fetch_req,
	input  wire logic [15:0] fetch_addr,
	input  wire logic        xmove_req,
	input  wire logic        xmove_write,
	input  wire logic        xmove_indexed,
	input  wire logic [15:0] data_pointer,
	input  wire logic [7:0]  index_addr,
	input  wire logic [7:0]  xmove_wdata,
	input  wire logic [7:0]  int_addr,
	input  wire logic        int_indirect,
	input  wire logic [2:0]  vector_sel,
	input  wire logic        vector_req,
	output logic             core_reset,
	output logic             req_ready,
	output logic             rsp_valid,
	output logic [7:0]       rsp_data,
	output logic             rsp_internal,
	output logic [15:0]      int_rom_addr,
	output logic [15:0]      vector_addr,
	output logic             iram_sel,
	output logic             sfr_sel,
	output logic             int_addr_err,
	output logic             addr_latch,
	output logic             fetch_strobe_n,
	input  wire logic [7:0]  low_address_data_port_in,
	output logic [7:0]       low_address_data_port_out,
	output logic             low_address_data_port_oe_n,
	output logic [7:0]       high_address_port_out,
	output logic             high_address_port_oe_n,
	output logic [7:0]       alternate_function_port_out,
	output logic             alternate_function_port_oe_n
);

////////////////////////////////////////////////////////////////////////////////
	function automatic logic rom_hit(input logic ext_all, input logic [15:0] a);
		rom_hit = !ext_all && (a <= `MSS_INT_ROM_TOP);
	endfunction : rom_hit

	function automatic logic [15:0] vector_of(input logic [2:0] sel);
		vector_of = `MSS_VEC_BASE + (16'(sel) * `MSS_VEC_STEP);
	endfunction : vector_of

	typedef struct packed {
		logic [2:0]    rst_sync;
		logic [2:0]    ea_sync;
		logic [7:0]    rst_cnt;
		logic          in_reset;
		logic          ext_all;
		mss_state_type st;
		mss_op_type    op;
		logic          xidx;
		logic [15:0]   addr;
		logic [7:0]    wdata;
		logic [7:0]    rdata;
		logic          rsp;
		logic          internal;
		logic [15:0]   rom_addr;
		logic          ale;
		logic          psen_n;
		logic          rd_n;
		logic          wr_n;
		logic          p0_oe_n;
		logic          p2_oe_n;
		logic [7:0]    p0_out;
		logic [7:0]    p2_out;
	} mss_regs_type;

	mss_regs_type q_r;
	mss_regs_type q_nxt;
	logic         rst_seen;

////////////////////////////////////////////////////////////////////////////////
	// reset pin synchroniser and hold counter
	always_comb begin
		q_nxt = q_r;
		q_nxt.rsp = 1'b0;
		q_nxt.rst_sync = {q_r.rst_sync[1:0], reset_pin};
		q_nxt.ea_sync = {q_r.ea_sync[1:0], external_fetch_select};
		rst_seen = q_r.rst_sync[1] && q_r.rst_sync[2];
		if (rst_seen) begin
			if (q_r.rst_cnt != RESET_CLKS[7:0] - 8'h01) begin
				q_nxt.rst_cnt = q_r.rst_cnt + 8'h01;
			end else begin
				q_nxt.in_reset = 1'b1; // RULE1
			end
		end else if (!q_r.rst_sync[1] && !q_r.rst_sync[2]) begin
			// hold count restarts once the pin is seen low
			q_nxt.rst_cnt = 8'h00;
			q_nxt.in_reset = 1'b0;
		end

		// strapping level is only taken while held in reset
		if (q_r.in_reset) begin
			if (q_r.ea_sync[1] == q_r.ea_sync[2]) begin
				q_nxt.ext_all = !q_r.ea_sync[2]; // RULE10 RULE11
			end
			q_nxt.st = MSS_IDLE;
			q_nxt.ale = 1'b0;
			q_nxt.psen_n = 1'b1;
			q_nxt.rd_n = 1'b1;
			q_nxt.wr_n = 1'b1;
			q_nxt.p0_oe_n = 1'b1;
			q_nxt.p2_oe_n = 1'b1;
		end else begin
			// bus cycle sequencer, one request at a time
			case (q_r.st)
				MSS_IDLE: begin
					// fetch wins over a data move in the same cycle
					if (fetch_req) begin
						q_nxt.op = MSS_OP_FETCH;
						q_nxt.xidx = 1'b0;
						q_nxt.addr = fetch_addr; // RULE9
						if (rom_hit(q_r.ext_all, fetch_addr)) begin
							q_nxt.internal = 1'b1; // RULE11
							q_nxt.rom_addr = fetch_addr;
							q_nxt.rsp = 1'b1;
						end else begin
							q_nxt.internal = 1'b0; // RULE12
							q_nxt.st = MSS_ADDR;
						end
					end else if (xmove_req) begin
						q_nxt.op = xmove_write ? MSS_OP_WRITE : MSS_OP_READ;
						q_nxt.addr = xmove_indexed ? {8'h00, index_addr} // RULE14
							: data_pointer; // RULE13
						q_nxt.wdata = xmove_wdata;
						q_nxt.xidx = xmove_indexed;
						q_nxt.internal = 1'b0;
						q_nxt.st = MSS_ADDR;
					end
				end

				MSS_ADDR: begin
					q_nxt.ale = 1'b1; // RULE2
					q_nxt.p0_out = q_r.addr[7:0]; // RULE4
					q_nxt.p0_oe_n = 1'b0;
					q_nxt.p2_out = q_r.addr[15:8]; // RULE5
					// indexed moves leave the high port undriven
					q_nxt.p2_oe_n = q_r.xidx;
					q_nxt.st = MSS_LATCH;
				end

				MSS_LATCH: begin
					// first port turns round to input for fetch and read
					q_nxt.ale = 1'b0;
					q_nxt.st = MSS_STROBE;
					case (q_r.op)
						MSS_OP_FETCH: begin
							q_nxt.psen_n = 1'b0; // RULE3 RULE18
							q_nxt.p0_oe_n = 1'b1;
						end
						MSS_OP_READ: begin
							q_nxt.rd_n = 1'b0; // RULE6 RULE18
							q_nxt.p0_oe_n = 1'b1;
						end
						MSS_OP_WRITE: begin
							q_nxt.wr_n = 1'b0; // RULE6 RULE18
							q_nxt.p0_out = q_r.wdata; // RULE4
						end
						default: begin
							q_nxt.st = MSS_IDLE;
						end
					endcase
				end

				MSS_STROBE: begin
					// byte taken while the strobe is still low
					q_nxt.rdata = low_address_data_port_in;
					q_nxt.psen_n = 1'b1;
					q_nxt.rd_n = 1'b1;
					q_nxt.wr_n = 1'b1;
					q_nxt.st = MSS_DONE;
				end

				MSS_DONE: begin
					q_nxt.p0_oe_n = 1'b1;
					q_nxt.p2_oe_n = 1'b1;
					q_nxt.rsp = 1'b1;
					q_nxt.st = MSS_IDLE;
				end
				default: begin
					q_nxt.st = MSS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			q_r <= '{
				rst_sync: 3'h0,
				ea_sync:  3'h0,
				rst_cnt:  8'h00,
				in_reset: 1'b1,
				ext_all:  1'b0,
				st:       MSS_IDLE,
				op:       MSS_OP_FETCH,
				xidx:     1'b0,
				addr:     16'h0000,
				wdata:    8'h00,
				rdata:    8'h00,
				rsp:      1'b0,
				internal: 1'b0,
				rom_addr: 16'h0000,
				ale:      1'b0,
				psen_n:   1'b1,
				rd_n:     1'b1,
				wr_n:     1'b1,
				p0_oe_n:  1'b1,
				p2_oe_n:  1'b1,
				p0_out:   8'h00,
				p2_out:   8'h00
			};
		end else begin
			q_r <= q_nxt;
		end
	end

////////////////////////////////////////////////////////////////////////////////
	// vector table; vectors are only addresses, code there runs normally
	always_comb begin
		vector_addr = 16'h0000;
		if (vector_req && vector_sel < 3'(`MSS_VEC_COUNT)) begin
			vector_addr = vector_of(vector_sel); // RULE7 RULE8
		end
	end

	// internal data decode
	always_comb begin
		iram_sel = 1'b0;
		sfr_sel = 1'b0;
		int_addr_err = 1'b0;
		if (int_addr < `MSS_SFR_BASE) begin
			iram_sel = 1'b1; // RULE15
		end else if (!int_indirect) begin
			// direct upper half always reaches the special area
			sfr_sel = 1'b1; // RULE16
		end else if (int_addr <= `MSS_IRAM_TOP) begin
			iram_sel = 1'b1; // RULE17
		end else begin
			int_addr_err = 1'b1; // RULE15
		end
	end

	assign core_reset = q_r.in_reset;
	assign req_ready = !q_r.in_reset && q_r.st == MSS_IDLE;
	assign rsp_valid = q_r.rsp;
	assign rsp_data = q_r.rdata;
	assign rsp_internal = q_r.internal;
	assign int_rom_addr = q_r.rom_addr;
	assign addr_latch = q_r.ale;
	assign fetch_strobe_n = q_r.psen_n;
	assign low_address_data_port_out = q_r.p0_out;
	assign low_address_data_port_oe_n = q_r.p0_oe_n;
	assign high_address_port_out = q_r.p2_out;
	assign high_address_port_oe_n = q_r.p2_oe_n;

	always_comb begin
		alternate_function_port_out = 8'hFF;
		alternate_function_port_out[`MSS_RD_BIT] = q_r.rd_n; // RULE6
		alternate_function_port_out[`MSS_WR_BIT] = q_r.wr_n; // RULE6
	end

	assign alternate_function_port_oe_n = q_r.rd_n && q_r.wr_n;

endmodule : mss_memory_space_select

// *** hw/mss_defs.svh ***
/*
 * mss_defs.svh: offsets, vector addresses, map limits and timing counts
 * for the memory space select and external bus block.
 * Assumes inclusion by bare name from the module and testbench.
 */
`ifndef MSS_DEFS_SVH
`define MSS_DEFS_SVH

`define MSS_RESET_MC          2
`define MSS_MC_CLKS           12
`define MSS_RESET_CLKS        (`MSS_RESET_MC * `MSS_MC_CLKS)
`define MSS_INT_ROM_TOP       16'h0FFF
`define MSS_VEC_BASE          16'h0003
`define MSS_VEC_STEP          16'h0008
`define MSS_VEC_COUNT         5
`define MSS_IRAM_TOP          8'hBF
`define MSS_SFR_BASE          8'h80
`define MSS_LOW_ADDR_BIT      0
`define MSS_HIGH_ADDR_BIT     8
`define MSS_RD_BIT            7
`define MSS_WR_BIT            6
`define MSS_PH_ALE            3'h0
`define MSS_PH_HOLD           3'h1
`define MSS_PH_STROBE         3'h3
`define MSS_PH_LAST           3'h2

`endif

// *** hw/mss_pkg.sv ***
/*
 * mss_pkg.sv: types for the memory space select and external bus block.
 * Assumes mss_defs.svh is on the include path.
 */
package mss_pkg;
	typedef enum logic [2:0] {
		MSS_IDLE   = 3'h0,
		MSS_ADDR   = 3'h1,
		MSS_LATCH  = 3'h3,
		MSS_STROBE = 3'h2,
		MSS_DONE   = 3'h6
	} mss_state_type;

	typedef enum logic [1:0] {
		MSS_OP_FETCH = 2'h0,
		MSS_OP_READ  = 2'h1,
		MSS_OP_WRITE = 2'h2
	} mss_op_type;

	typedef enum logic [1:0] {
		MSS_TGT_NONE = 2'h0,
		MSS_TGT_RAM  = 2'h1,
		MSS_TGT_SFR  = 2'h2
	} mss_tgt_type;
endpackage : mss_pkg

// *** tb/mss_ext_mem.sv ***
/*
 * external program and data memory with address latch.
 * assumes the block's strobes and port outputs, registered on sys_clk.
 */
`timescale 1ns/100ps
module mss_ext_mem (
	input wire logic       sys_clk,
	input wire logic       addr_latch,
	input wire logic       fetch_strobe_n,
	input wire logic [7:0] low_address_data_port_out,
	input wire logic [7:0] high_address_port_out,
	input wire logic       high_address_port_oe_n,
	input wire logic [7:0] alternate_function_port_out,
	output logic     [7:0] low_address_data_port_in
);
	logic [15:0] lat_r;
	logic [7:0]  last_r = 8'h00;
	logic [7:0]  xram [0:65535];
	//////////////////////////////////////////////////
	always @(posedge sys_clk) begin
		// undriven high port floats up
		if (addr_latch)
			lat_r <= {high_address_port_oe_n ? 8'hFF : high_address_port_out,
				low_address_data_port_out};
		if (!alternate_function_port_out[6])
			xram[lat_r] <= low_address_data_port_out;
		last_r <= low_address_data_port_in;
	end
	// released bus toggles every cycle
	always_comb begin
		if (!fetch_strobe_n)
			low_address_data_port_in = lat_r[7:0] ^ lat_r[15:8];
		else if (!alternate_function_port_out[7])
			low_address_data_port_in = xram[lat_r];
		else
			low_address_data_port_in = ~last_r;
	end
endmodule : mss_ext_mem

// *** tb/mss_memory_space_select_assertions.sv ***
/*
 * checker for bus strobes, vectors and internal data decode.
 * bound to every instance of mss_memory_space_select.
 */
`timescale 1ns/100ps
module mss_chk (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        rsp_valid,
	input wire logic        rsp_internal,
	input wire logic [15:0] int_rom_addr,
	input wire logic [2:0]  vector_sel,
	input wire logic        vector_req,
	input wire logic [15:0] vector_addr,
	input wire logic [7:0]  int_addr,
	input wire logic        int_indirect,
	input wire logic        iram_sel,
	input wire logic        sfr_sel,
	input wire logic        int_addr_err,
	input wire logic        addr_latch,
	input wire logic        fetch_strobe_n,
	input wire logic        low_address_data_port_oe_n,
	input wire logic        alternate_function_port_oe_n,
	input wire logic [7:0]  alternate_function_port_out
);
	logic dstb;
	assign dstb = alternate_function_port_out[7:6] != 2'h3;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	//////////////////////////////////////////////////
	AST_NO_OVERLAP: assert property (!(dstb && !fetch_strobe_n))
		else $error("fetch and data strobes overlap");
	AST_ALE_TO_RSP: assert property ($rose(addr_latch) |-> ##3 rsp_valid)
		else $error("bus cycle length wrong");
	AST_STB_AFTER_ALE: assert property ($fell(addr_latch) |-> dstb || !fetch_strobe_n)
		else $error("no strobe after latch");
	AST_FETCH_SHORT: assert property ($fell(fetch_strobe_n) |=> fetch_strobe_n)
		else $error("fetch strobe too long");
	AST_BUS_RELEASE: assert property (!fetch_strobe_n || !alternate_function_port_out[7]
		|-> low_address_data_port_oe_n)
		else $error("bus driven during read");
	AST_VECTOR: assert property (vector_req && vector_sel < 3'h5
		|-> vector_addr == 16'h0003 + {10'h000, vector_sel, 3'h0})
		else $error("vector address wrong");
	AST_SFR_DIRECT: assert property (!int_indirect && int_addr[7] |-> sfr_sel && !iram_sel)
		else $error("direct upper not special");
	AST_IND_RAM: assert property (int_indirect && int_addr <= 8'hBF
		|-> iram_sel && !sfr_sel && !int_addr_err)
		else $error("indirect ram decode wrong");
	AST_INT_ROM: assert property (rsp_valid && rsp_internal |-> int_rom_addr <= 16'h0FFF)
		else $error("internal fetch above rom");
	AST_AF_OE: assert property (alternate_function_port_oe_n == !dstb)
		else $error("strobe port enable wrong");
	AST_WR_DRIVE: assert property (!alternate_function_port_out[6]
		|-> !low_address_data_port_oe_n)
		else $error("bus not driven during write");
	cover property (rsp_valid && rsp_internal);
	cover property (!fetch_strobe_n);
	cover property (!alternate_function_port_out[7]);
	cover property (!alternate_function_port_out[6]);
endmodule : mss_chk
bind mss_memory_space_select mss_chk mss_chk_inst (.*);

// *** tb/test_mss_memory_space_select.sv ***
/*
 * directed scenarios for the memory space select block.
 * assumes package, design, memory model and checker compiled first.
 */
`timescale 1ns/100ps
`include "mss_defs.svh"
module test_mss_memory_space_select;
	logic sys_clk, rst_n, reset_pin, external_fetch_select, fetch_req, xmove_req;
	logic xmove_write, xmove_indexed, int_indirect, vector_req, core_reset, req_ready;
	logic rsp_valid, rsp_internal, iram_sel, sfr_sel, int_addr_err, addr_latch;
	logic fetch_strobe_n, low_address_data_port_oe_n, high_address_port_oe_n;
	logic alternate_function_port_oe_n;
	logic [15:0] fetch_addr, data_pointer, int_rom_addr, vector_addr;
	logic [7:0] index_addr, xmove_wdata, int_addr, rsp_data, alternate_function_port_out;
	logic [7:0] low_address_data_port_in, low_address_data_port_out, high_address_port_out;
	logic [2:0] vector_sel;
	int err_count = 0;
	int tests_run = 0;
	mss_memory_space_select mss_memory_space_select_inst (.*);
	mss_ext_mem mss_ext_mem_inst (.*);
	always #10 sys_clk = ~sys_clk;
	//////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic pin_reset(input logic ea, input int len);
		@(posedge sys_clk);
		reset_pin <= 1'h1;
		external_fetch_select <= ea;
		repeat (len) @(posedge sys_clk);
		reset_pin <= 1'h0;
		chk({15'h0, core_reset}, {15'h0, len > `MSS_RESET_CLKS});
		repeat (8) @(posedge sys_clk);
		chk({15'h0, core_reset}, 16'h0);
	endtask : pin_reset
	task automatic xfer(input logic f, input logic w, input logic ix,
		input logic [15:0] a, input logic [7:0] d);
		chk({15'h0, req_ready}, 16'h1);
		@(posedge sys_clk);
		fetch_req <= f;
		xmove_req <= !f;
		xmove_write <= w;
		xmove_indexed <= ix;
		fetch_addr <= a;
		data_pointer <= a;
		index_addr <= a[7:0];
		xmove_wdata <= d;
		@(posedge sys_clk);
		fetch_req <= 1'h0;
		xmove_req <= 1'h0;
		#1;
		for (int n = 0; n < 9 && rsp_valid !== 1'h1; n++) begin
			@(posedge sys_clk);
			#1;
		end
		chk({15'h0, rsp_valid}, 16'h1);
	endtask : xfer
	task automatic t_fetch(input logic [15:0] a, input logic internal);
		xfer(1'h1, 1'h0, 1'h0, a, 8'h00);
		chk({15'h0, rsp_internal}, {15'h0, internal});
		if (internal)
			chk(int_rom_addr, a);
		else
			chk({8'h00, rsp_data}, {8'h00, a[7:0] ^ a[15:8]});
	endtask : t_fetch
	task automatic t_xdata;
		xfer(1'h0, 1'h1, 1'h0, 16'h1234, 8'h5A);
		xfer(1'h0, 1'h1, 1'h0, 16'h0034, 8'hA5);
		xfer(1'h0, 1'h0, 1'h0, 16'h1234, 8'h00);
		chk({8'h00, rsp_data}, 16'h005A);
		xfer(1'h0, 1'h1, 1'h1, 16'h0077, 8'hC3);
		xfer(1'h0, 1'h0, 1'h1, 16'h0077, 8'h00);
		chk({8'h00, rsp_data}, 16'h00C3);
	endtask : t_xdata
	task automatic t_decode;
		logic [7:0] tbl [6] = '{8'h00, 8'h7F, 8'h80, 8'hBF, 8'hC0, 8'hFF};
		for (int i = 0; i < 12; i++) begin
			@(posedge sys_clk);
			int_addr <= tbl[i / 2];
			int_indirect <= i[0];
			#1;
			chk({13'h0, iram_sel, sfr_sel, int_addr_err}, {13'h0,
				i[0] ? int_addr <= 8'hBF : !int_addr[7], !i[0] && int_addr[7],
				i[0] && int_addr > 8'hBF});
		end
	endtask : t_decode
	task automatic t_vectors;
		for (int s = 0; s < 9; s++) begin
			@(posedge sys_clk);
			vector_sel <= s[2:0];
			vector_req <= s < 8;
			#1;
			chk(vector_addr, s < 5 ? 16'h0003 + 16'(s * 8) : 16'h0000);
		end
	endtask : t_vectors
	task automatic tally_and_finish;
		$display("tests_run=%0d err_count=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	//////////////////////////////////////////////////
	initial begin
		{sys_clk, rst_n, reset_pin, external_fetch_select, fetch_req, xmove_req} = 6'h00;
		{xmove_write, xmove_indexed, int_indirect, vector_req, vector_sel} = 7'h00;
		{fetch_addr, data_pointer, index_addr, xmove_wdata, int_addr} = 56'h0;
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'h1;
		pin_reset(1'h0, 40);
		t_fetch(16'h0003, 1'h0);
		t_fetch(16'h0FFF, 1'h0);
		pin_reset(1'h1, 12);
		pin_reset(1'h1, 40);
		t_fetch(16'h0FFF, 1'h1);
		t_fetch(16'h1000, 1'h0);
		t_fetch(16'hFFFF, 1'h0);
		t_xdata();
		t_decode();
		t_vectors();
		tally_and_finish();
	end
	initial begin
		#1000000;
		err_count++;
		tally_and_finish();
	end
endmodule : test_mss_memory_space_select
